/* File: dpa_pkg.sv */
// shared constants and types for the device parts admin command block
package dpa_pkg;
  // wishbone byte offsets
  localparam logic [11:0] ADR_CMD     = 12'h000;
  localparam logic [11:0] ADR_STATUS  = 12'h004;
  localparam logic [11:0] ADR_RESCAP  = 12'h008;
  localparam logic [11:0] ADR_REQLEN  = 12'h00c;
  localparam logic [11:0] ADR_PRESENT = 12'h010;
  localparam logic [11:0] ADR_LIVE    = 12'h040;
  localparam logic [11:0] ADR_REQBUF  = 12'h100;
  localparam logic [11:0] ADR_RESBUF  = 12'h200;
  // command register fields
  localparam int CMD_OPC_LSB   = 0;
  localparam int CMD_TYPE_LSB  = 8;
  localparam int CMD_FLAGS_LSB = 16;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_STOP_BIT = 1;
  localparam int ST_CODE_LSB = 8;
  localparam int ST_LEN_LSB  = 16;
  // command opcodes
  localparam logic [7:0] OPC_META = 8'h0e;
  localparam logic [7:0] OPC_CAPT = 8'h0f;
  localparam logic [7:0] OPC_REST = 8'h10;
  localparam logic [7:0] OPC_MODE = 8'h11;
  // command types and flags
  localparam logic [7:0] META_SIZE     = 8'h00;
  localparam logic [7:0] META_COUNT    = 8'h01;
  localparam logic [7:0] META_LIST     = 8'h02;
  localparam logic [7:0] CAPT_SELECTED = 8'h00;
  localparam logic [7:0] CAPT_ALL      = 8'h01;
  localparam int         MODE_STOP_BIT = 0;
  localparam int         PART_OPT_BIT  = 0;
  // completion codes
  localparam logic [7:0] ST_OK     = 8'h00;
  localparam logic [7:0] ST_ENOMEM = 8'h0c;
  localparam logic [7:0] ST_EBUSY  = 8'h10;
  localparam logic [7:0] ST_EINVAL = 8'h16;
  // parts, in their fixed exchange order
  localparam int         NUM_PARTS      = 6;
  localparam int         PART_IDX_W     = 3;
  localparam int         IDX_DEV_FEAT   = 0;
  localparam logic [7:0] PART_LEN_WORDS = 8'h01;
  localparam int         PART_REC_BYTES = 8;
  // reset values
  localparam logic [5:0]  PRESENT_RST = 6'h3f;
  localparam logic [31:0] PART_RST    = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  len;
    logic [7:0]  flags;
    logic [15:0] ptype;
  } dpa_hdr_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dpa_wbreq_t;

  typedef struct packed {
    logic                  en;
    logic                  byDriver;
    logic [PART_IDX_W-1:0] idx;
    logic [31:0]           data;
  } dpa_partupd_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_DISP  = 4'h1,
    S_META  = 4'h2,
    S_SEL   = 4'h3,
    S_EMIT  = 4'h4,
    S_RVAL  = 4'h5,
    S_RCOM  = 4'h6,
    S_FLUSH = 4'h7
  } dpa_state_t;
endpackage : dpa_pkg

/* File: dpa_part_cell.sv */
// per-part storage cell: live value plus a dormant staged value
`timescale 1ns/10ps
module dpa_part_cell #(
  parameter int           W       = 32,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  logic         clk,
  input  logic         rst,
  // updates from the device itself
  input  logic         devWrEn,
  input  logic [W-1:0] devWrData,
  // restore staging and resume
  input  logic         stageEn,
  input  logic [W-1:0] stageData,
  input  logic         applyEn,
  // current value
  output logic [W-1:0] liveVal
);
  logic [W-1:0] staged;
  logic [W-1:0] next_staged;
  logic [W-1:0] next_liveVal;
  logic         held;
  logic         next_held;

  // staged value wins over a device update on resume
  always_comb begin
    next_liveVal = liveVal;
    next_staged  = staged;
    next_held    = held;
    if (applyEn && held) begin
      next_liveVal = staged;
      next_held    = 1'b0;
    end else if (devWrEn) begin
      next_liveVal = devWrData;
    end
    if (stageEn) begin
      next_staged = stageData;
      next_held   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      liveVal <= RST_VAL;
      staged  <= RST_VAL;
      held    <= 1'b0;
    end else begin
      liveVal <= next_liveVal;
      staged  <= next_staged;
      held    <= next_held;
    end
  end
endmodule : dpa_part_cell

/* File: dpa_admin_cmd.sv */
// device parts admin command handler with a wishbone register slave
// Notes on behaviour
// - opcode 0xe queries parts metadata
// - type 0 returns total byte size
// - type 1 returns header entry count
// - type 2 returns count then header list
// - result buffer too small gives out-of-memory
// - opcode 0xf captures parts
// - capture type 0 selected, type 1 all
// - missing requested parts are silently skipped
// - opcode 0x10 restores parts, no result
// - successful restore holds exactly supplied values
// - restored values apply only on resume
// - failed restore changes nothing
// - opcode 0x11 sets mode, no result
// - stop halts notifications and memory access
// - stopped parts change only by driver
// - stop writes back observed descriptors first
// - flags zero resumes normal operation
// - failed mode set changes nothing
// - parts exchanged in fixed dependency order
// - optional part marked by flags bit 0
// - restore refused unless device stopped
// - success reports ok, failure anything else
`timescale 1ns/10ps
module dpa_admin_cmd #(
  parameter int                             REQ_DEPTH   = 32,
  parameter int                             RES_DEPTH   = 32,
  parameter logic [dpa_pkg::NUM_PARTS-1:0] PRESENT_INIT = dpa_pkg::PRESENT_RST
) (
  // clock and reset
  input  logic                  clk,
  input  logic                  rst,
  // wishbone slave
  input  dpa_pkg::dpa_wbreq_t   wbReq,
  output logic                  wbAck,
  output logic [31:0]           wbDatR,
  // device side
  input  dpa_pkg::dpa_partupd_t partUpd,
  input  logic                  flushDone,
  output logic                  flushReq,
  output logic                  notifyEn,
  output logic                  memAccessEn,
  output logic                  cmdDone
);
  import dpa_pkg::*;

  localparam int          RQ_AW   = $clog2(REQ_DEPTH);
  localparam int          RS_AW   = $clog2(RES_DEPTH);
  localparam int          QW      = RQ_AW + 1;
  localparam int          PW      = RS_AW + 1;
  localparam logic [11:0] REQ_END = ADR_REQBUF + 12'(REQ_DEPTH * 4);
  localparam logic [11:0] RES_END = ADR_RESBUF + 12'(RES_DEPTH * 4);
  localparam logic [11:0] LIV_END = ADR_LIVE + 12'(NUM_PARTS * 4);

  logic [31:0]                 reqBuf [REQ_DEPTH];
  logic [31:0]                 resBuf [RES_DEPTH];
  logic [NUM_PARTS-1:0][31:0]  liveVal;
  dpa_state_t                  state, next_state;
  logic [7:0]                  cmdOpc, next_cmdOpc, cmdType, next_cmdType, cmdFlags, next_cmdFlags;
  logic [7:0]                  cmdCode, next_cmdCode, finCode;
  logic [PW-1:0]               wptr, next_wptr, resCap, next_resCap, capEff, need;
  logic [QW-1:0]               reqLen, next_reqLen, idx, next_idx;
  logic [NUM_PARTS-1:0]        present, next_present, selMask, next_selMask, stageEn;
  logic [15:0]                 lastType, next_lastType;
  logic                        haveLast, next_haveLast, half, next_half;
  logic                        stopped, next_stopped, next_cmdDone, doFinish, apply, devWr;
  logic                        resWe, busAcc, busWr, cmdWr;
  logic [RS_AW-1:0]            resWa;
  logic [31:0]                 resWd, stageData, next_wbDat, offs;
  logic [3:0]                  cnt;
  dpa_hdr_t                    rHdr;
  logic [31:0]                 rVal;
  logic [PART_IDX_W-1:0]       pIdx;

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      laneMerge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : laneMerge

  // header for part p; device features is the one optional part
  function automatic logic [31:0] partHdr(input logic [PART_IDX_W-1:0] p);
    dpa_hdr_t h;
    h.len   = PART_LEN_WORDS;
    h.flags = (int'(p) == IDX_DEV_FEAT) ? 8'(1 << PART_OPT_BIT) : 8'h00;
    h.ptype = 16'(p);
    return h;
  endfunction : partHdr

  // part storage, one cell per part
  assign devWr = partUpd.en && (!stopped || partUpd.byDriver);
  for (genvar p = 0; p < NUM_PARTS; p++) begin : g_part
    dpa_part_cell #(
      .W       (32),
      .RST_VAL (PART_RST)
    ) u_cell (
      .clk       (clk),
      .rst       (rst),
      .devWrEn   (devWr && (partUpd.idx == PART_IDX_W'(p))),
      .devWrData (partUpd.data),
      .stageEn   (stageEn[p]),
      .stageData (stageData),
      .applyEn   (apply),
      .liveVal   (liveVal[p])
    );
  end

  // bus decode; ack alternates so each access is taken once
  always_comb begin
    busAcc = wbReq.cyc && wbReq.stb && !wbAck;
    busWr  = busAcc && wbReq.we;
    cmdWr  = busWr && (wbReq.adr == ADR_CMD) && (state == S_IDLE);
    offs   = '0;
    next_wbDat = 32'h0000_0000;
    if (wbReq.adr == ADR_CMD) begin
      next_wbDat = {8'h00, cmdFlags, cmdType, cmdOpc};
    end else if (wbReq.adr == ADR_STATUS) begin
      next_wbDat = {16'(wptr), cmdCode, 6'h00, stopped, state != S_IDLE};
    end else if (wbReq.adr == ADR_RESCAP) begin
      next_wbDat = 32'(resCap);
    end else if (wbReq.adr == ADR_REQLEN) begin
      next_wbDat = 32'(reqLen);
    end else if (wbReq.adr == ADR_PRESENT) begin
      next_wbDat = 32'(present);
    end else if (wbReq.adr >= ADR_LIVE && wbReq.adr < LIV_END) begin
      offs       = 32'(wbReq.adr - ADR_LIVE);
      next_wbDat = liveVal[offs[2 +: PART_IDX_W]];
    end else if (wbReq.adr >= ADR_REQBUF && wbReq.adr < REQ_END) begin
      offs       = 32'(wbReq.adr - ADR_REQBUF);
      next_wbDat = reqBuf[offs[2 +: RQ_AW]];
    end else if (wbReq.adr >= ADR_RESBUF && wbReq.adr < RES_END) begin
      offs       = 32'(wbReq.adr - ADR_RESBUF);
      next_wbDat = resBuf[offs[2 +: RS_AW]];
    end
  end

  // configuration writes are refused while a command runs
  always_comb begin
    next_resCap  = resCap;
    next_reqLen  = reqLen;
    next_present = present;
    if (busWr && state == S_IDLE) begin
      if (wbReq.adr == ADR_RESCAP) begin
        next_resCap = PW'(laneMerge(32'(resCap), wbReq.dat, wbReq.sel));
      end else if (wbReq.adr == ADR_REQLEN) begin
        next_reqLen = QW'(laneMerge(32'(reqLen), wbReq.dat, wbReq.sel));
      end else if (wbReq.adr == ADR_PRESENT) begin
        next_present = NUM_PARTS'(laneMerge(32'(present), wbReq.dat, wbReq.sel));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck   <= 1'b0;
      wbDatR  <= 32'h0000_0000;
      resCap  <= '0;
      reqLen  <= '0;
      present <= PRESENT_INIT;
    end else begin
      wbAck   <= busAcc;
      wbDatR  <= next_wbDat;
      resCap  <= next_resCap;
      reqLen  <= next_reqLen;
      present <= next_present;
    end
  end

  // buffers: request written by software when idle, result by the sequencer
  always_ff @(posedge clk) begin
    if (busWr && state == S_IDLE && wbReq.adr >= ADR_REQBUF && wbReq.adr < REQ_END) begin
      reqBuf[offs[2 +: RQ_AW]] <= laneMerge(reqBuf[offs[2 +: RQ_AW]], wbReq.dat, wbReq.sel);
    end
    if (resWe) begin
      resBuf[resWa] <= resWd;
    end
  end

  // command sequencer
  always_comb begin
    cnt = '0;
    for (int p = 0; p < NUM_PARTS; p++) begin
      cnt = cnt + 4'(present[p]);
    end
    capEff  = (resCap > PW'(RES_DEPTH)) ? PW'(RES_DEPTH) : resCap;
    need    = (cmdType == META_LIST) ? PW'(cnt) + PW'(2) : PW'(2);
    rHdr    = dpa_hdr_t'(reqBuf[idx[RQ_AW-1:0]]);
    rVal    = reqBuf[RQ_AW'(idx[RQ_AW-1:0] + 1'b1)];
    pIdx    = idx[PART_IDX_W-1:0];
    next_state    = state;
    next_cmdOpc   = cmdOpc;
    next_cmdType  = cmdType;
    next_cmdFlags = cmdFlags;
    next_cmdCode  = cmdCode;
    next_cmdDone  = 1'b0;
    next_wptr     = wptr;
    next_idx      = idx;
    next_half     = half;
    next_selMask  = selMask;
    next_lastType = lastType;
    next_haveLast = haveLast;
    next_stopped  = stopped;
    doFinish  = 1'b0;
    finCode   = ST_OK;
    apply     = 1'b0;
    stageEn   = '0;
    stageData = rVal;
    resWe     = 1'b0;
    resWa     = wptr[RS_AW-1:0];
    resWd     = 32'h0000_0000;
    case (state)
      S_IDLE: begin
        if (cmdWr) begin
          next_cmdOpc   = wbReq.dat[CMD_OPC_LSB +: 8];
          next_cmdType  = wbReq.dat[CMD_TYPE_LSB +: 8];
          next_cmdFlags = wbReq.dat[CMD_FLAGS_LSB +: 8];
          next_wptr     = '0;
          next_idx      = '0;
          next_half     = 1'b0;
          next_haveLast = 1'b0;
          next_state    = S_DISP;
        end
      end
      S_DISP: begin
        if (cmdOpc == OPC_META) begin
          if (cmdType > META_LIST) begin
            doFinish = 1'b1;
            finCode  = ST_EINVAL;
          end else if (need > capEff) begin
            doFinish = 1'b1;
            finCode  = ST_ENOMEM;
          end else begin
            resWe      = 1'b1;
            resWd      = (cmdType == META_SIZE) ? 32'(cnt) * 32'(PART_REC_BYTES) : 32'(cnt);
            next_wptr  = PW'(1);
            next_state = S_META;
          end
        end else if (cmdOpc == OPC_CAPT) begin
          next_selMask = present;
          if (cmdType == CAPT_ALL) begin
            next_state = S_EMIT;
          end else if (cmdType == CAPT_SELECTED) begin
            next_selMask = '0;
            next_state   = (reqLen == '0) ? S_EMIT : S_SEL;
          end else begin
            doFinish = 1'b1;
            finCode  = ST_EINVAL;
          end
        end else if (cmdOpc == OPC_REST) begin
          if (!stopped) begin
            doFinish = 1'b1;
            finCode  = ST_EBUSY;
          end else if (reqLen == '0 || reqLen[0]) begin
            doFinish = 1'b1;
            finCode  = ST_EINVAL;
          end else begin
            next_state = S_RVAL;
          end
        end else if (cmdOpc == OPC_MODE) begin
          if (cmdFlags == 8'h00) begin
            apply        = 1'b1;
            next_stopped = 1'b0;
            doFinish     = 1'b1;
          end else if (cmdFlags == 8'(1 << MODE_STOP_BIT)) begin
            doFinish   = stopped;
            next_state = stopped ? S_IDLE : S_FLUSH;
          end else begin
            doFinish = 1'b1;
            finCode  = ST_EINVAL;
          end
        end else begin
          doFinish = 1'b1;
          finCode  = ST_EINVAL;
        end
      end
      S_META: begin
        if (wptr == PW'(1)) begin
          resWe     = 1'b1;
          next_wptr = PW'(2);
          doFinish  = (cmdType != META_LIST);
        end else begin
          if (present[pIdx]) begin
            resWe     = 1'b1;
            resWd     = partHdr(pIdx);
            next_wptr = wptr + 1'b1;
          end
          next_idx = idx + 1'b1;
          doFinish = (idx == QW'(NUM_PARTS - 1));
        end
      end
      S_SEL: begin
        // absent or unknown parts never enter the mask
        if (rHdr.ptype < 16'(NUM_PARTS) && present[rHdr.ptype[PART_IDX_W-1:0]]) begin
          next_selMask[rHdr.ptype[PART_IDX_W-1:0]] = 1'b1;
        end
        next_idx = idx + 1'b1;
        if (idx + 1'b1 >= reqLen) begin
          next_idx   = '0;
          next_state = S_EMIT;
        end
      end
      S_EMIT: begin
        // walking part indices in order keeps the dependency order
        if (selMask[pIdx] && !half) begin
          if (32'(wptr) + 32'd2 > 32'(capEff)) begin
            doFinish = 1'b1;
            finCode  = ST_ENOMEM;
          end else begin
            resWe     = 1'b1;
            resWd     = partHdr(pIdx);
            next_wptr = wptr + 1'b1;
            next_half = 1'b1;
          end
        end else begin
          if (half) begin
            resWe     = 1'b1;
            resWd     = liveVal[pIdx];
            next_wptr = wptr + 1'b1;
            next_half = 1'b0;
          end
          next_idx = idx + 1'b1;
          doFinish = (idx == QW'(NUM_PARTS - 1));
        end
      end
      S_RVAL: begin
        // whole request checked before anything is staged
        if (rHdr.ptype >= 16'(NUM_PARTS) || rHdr.len != PART_LEN_WORDS ||
            (haveLast && rHdr.ptype <= lastType) ||
            (int'(rHdr.ptype) == IDX_DEV_FEAT && rVal != liveVal[IDX_DEV_FEAT])) begin
          doFinish = 1'b1;
          finCode  = ST_EINVAL;
        end else begin
          next_lastType = rHdr.ptype;
          next_haveLast = 1'b1;
          next_idx      = idx + QW'(2);
          if (idx + QW'(2) >= reqLen) begin
            next_idx   = '0;
            next_state = S_RCOM;
          end
        end
      end
      S_RCOM: begin
        // optional parts and the verified feature word are not written
        if (!rHdr.flags[PART_OPT_BIT] && int'(rHdr.ptype) != IDX_DEV_FEAT) begin
          stageEn[rHdr.ptype[PART_IDX_W-1:0]] = 1'b1;
        end
        next_idx = idx + QW'(2);
        doFinish = (idx + QW'(2) >= reqLen);
      end
      S_FLUSH: begin
        if (flushDone) begin
          next_stopped = 1'b1;
          doFinish     = 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (doFinish) begin
      next_state   = S_IDLE;
      next_cmdCode = finCode;
      next_cmdDone = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= S_IDLE;
      cmdOpc      <= 8'h00;
      cmdType     <= 8'h00;
      cmdFlags    <= 8'h00;
      cmdCode     <= ST_OK;
      cmdDone     <= 1'b0;
      wptr        <= '0;
      idx         <= '0;
      half        <= 1'b0;
      selMask     <= '0;
      lastType    <= 16'h0000;
      haveLast    <= 1'b0;
      stopped     <= 1'b0;
      notifyEn    <= 1'b1;
      memAccessEn <= 1'b1;
      flushReq    <= 1'b0;
    end else begin
      state       <= next_state;
      cmdOpc      <= next_cmdOpc;
      cmdType     <= next_cmdType;
      cmdFlags    <= next_cmdFlags;
      cmdCode     <= next_cmdCode;
      cmdDone     <= next_cmdDone;
      wptr        <= next_wptr;
      idx         <= next_idx;
      half        <= next_half;
      selMask     <= next_selMask;
      lastType    <= next_lastType;
      haveLast    <= next_haveLast;
      stopped     <= next_stopped;
      notifyEn    <= !next_stopped;
      memAccessEn <= !next_stopped;
      flushReq    <= (next_state == S_FLUSH);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqStopAck;
    state == S_FLUSH ##0 flushDone;
  endsequence
  sequence seqDisp(logic [7:0] op);
    state == S_DISP ##0 cmdOpc == op;
  endsequence

  chk_meta_opcode: assert property (seqDisp(OPC_META) |=> state == S_META || cmdDone)
    else $error("metadata query not handled");
  chk_meta_size: assert property (seqDisp(OPC_META) ##0 cmdType == META_SIZE && need <= capEff
    |=> resBuf[0] == 32'($past(cnt)) * 32'(PART_REC_BYTES))
    else $error("metadata size word wrong");
  chk_meta_nomem: assert property (seqDisp(OPC_META) ##0 cmdType <= META_LIST && need > capEff
    |=> cmdDone && cmdCode == ST_ENOMEM)
    else $error("short result buffer not reported");
  chk_restore_stopped: assert property (seqDisp(OPC_REST) ##0 !stopped |=> cmdDone && cmdCode == ST_EBUSY)
    else $error("restore accepted while running");
  chk_restore_atomic: assert property (stageEn != '0 |-> state == S_RCOM)
    else $error("part staged outside commit");
  chk_stop_quiet: assert property (seqStopAck |=> stopped && !notifyEn && !memAccessEn && cmdDone)
    else $error("stop did not quiesce device");
  chk_flush_first: assert property ($rose(stopped) |-> $past(flushReq))
    else $error("stopped without descriptor write-back");
  chk_resume_ok: assert property (seqDisp(OPC_MODE) ##0 cmdFlags == 8'h00
    |=> !stopped && notifyEn && cmdDone && cmdCode == ST_OK)
    else $error("resume failed");
  chk_mode_err: assert property (cmdDone && cmdCode != ST_OK |-> $stable(stopped))
    else $error("failed command changed mode");
  chk_live_dormant: assert property (stopped && !apply && !(partUpd.en && partUpd.byDriver)
    |=> $stable(liveVal))
    else $error("part changed while stopped");
endmodule : dpa_admin_cmd

/* File: dpa_flush_partner.sv */
// stand-in for the queue engine that answers the stop flush request
`timescale 1ns/10ps
module dpa_flush_partner (
  // clock and reset
  input  logic clk,
  input  logic rst,
  // flush handshake
  input  logic flushReq,
  output logic flushDone
);
  logic [1:0] waitCnt;
  // write-back takes a few cycles; done is withdrawn as soon as the request goes
  always_ff @(posedge clk) begin
    if (rst || !flushReq) begin
      waitCnt <= 2'h0;
    end else if (waitCnt != 2'h3) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
  assign flushDone = flushReq && (waitCnt == 2'h3);
endmodule : dpa_flush_partner

/* File: tb_top.sv */
// self-checking bench for the parts admin command block
`timescale 1ns/10ps
module tb_top;
  import dpa_pkg::*;
  logic         clk        = 1'b0;
  logic         rst        = 1'b1;
  dpa_wbreq_t   wbReq      = '0;
  dpa_partupd_t partUpd    = '0;
  logic         wbAck, flushDone, flushReq, notifyEn, memAccessEn, cmdDone;
  logic [31:0]  wbDatR, rd;
  int           fail_count = 0;
  int           n_compared = 0;
  int           cycles     = 0;
  int           nDone      = 0;

  dpa_admin_cmd dpa_admin_cmd_i (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatR(wbDatR),
    .partUpd(partUpd), .flushDone(flushDone), .flushReq(flushReq), .notifyEn(notifyEn),
    .memAccessEn(memAccessEn), .cmdDone(cmdDone));
  dpa_flush_partner dpa_flush_partner_i (.clk(clk), .rst(rst), .flushReq(flushReq), .flushDone(flushDone));

  // 200 MHz clock and a cycle ceiling against hangs
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    nDone  <= nDone + int'(cmdDone === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // classic single cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      fail_count++;
    end
    rd = wbDatR;
    wbReq <= '0;
  endtask : wb

  // one-cycle update of part 2 from the device side
  task automatic upd(input logic drv, input logic [31:0] d);
    @(posedge clk);
    partUpd <= '{en: 1'b1, byDriver: drv, idx: 3'h2, data: d};
    @(posedge clk);
    partUpd <= '0;
  endtask : upd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // start a command and poll status until idle; rd then holds status
  task automatic cmd(input logic [7:0] opc, input logic [7:0] typ, input logic [7:0] flg, input logic [7:0] code);
    int n;
    int start;
    n     = 0;
    start = nDone;
    wb(1'b1, ADR_CMD, {8'h00, flg, typ, opc});
    do begin
      wb(1'b0, ADR_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 100);
    check({31'h0, rd[ST_BUSY_BIT]}, 32'h0);
    check({24'h0, rd[15:8]}, {24'h0, code});
    check(32'(nDone - start), 32'h1);
  endtask : cmd

  task automatic testMeta;
    wb(1'b1, ADR_RESCAP, 32'd32);
    cmd(OPC_META, META_SIZE, 8'h00, ST_OK);
    wb(1'b0, ADR_RESBUF, 32'h0);
    check(rd, 32'd48);
    wb(1'b0, ADR_RESBUF + 12'h4, 32'h0);
    check(rd, 32'h0);
    cmd(OPC_META, META_COUNT, 8'h00, ST_OK);
    wb(1'b0, ADR_RESBUF, 32'h0);
    check(rd, 32'd6);
    cmd(OPC_META, META_LIST, 8'h00, ST_OK);
    wb(1'b0, ADR_RESBUF + 12'h8, 32'h0);
    check(rd, 32'h0101_0000);
    wb(1'b0, ADR_RESBUF + 12'h1c, 32'h0);
    check(rd, 32'h0100_0005);
    wb(1'b1, ADR_RESCAP, 32'd1);
    cmd(OPC_META, META_SIZE, 8'h00, ST_ENOMEM);
    cmd(OPC_META, 8'h03, 8'h00, ST_EINVAL);
  endtask : testMeta

  task automatic testRestore;
    wb(1'b1, ADR_REQLEN, 32'd4);
    wb(1'b1, ADR_REQBUF, 32'h0101_0000);
    wb(1'b1, ADR_REQBUF + 12'h4, 32'h0);
    wb(1'b1, ADR_REQBUF + 12'h8, 32'h0100_0001);
    wb(1'b1, ADR_REQBUF + 12'hc, 32'h0000_0055);
    cmd(OPC_REST, 8'h00, 8'h00, ST_EBUSY);
    cmd(OPC_MODE, 8'h00, 8'h01, ST_OK);
    check({31'h0, rd[ST_STOP_BIT]}, 32'h1);
    check({29'h0, flushReq, notifyEn, memAccessEn}, 32'h0);
    cmd(OPC_MODE, 8'h00, 8'h01, ST_OK);
    upd(1'b0, 32'h0000_0099);
    wb(1'b0, ADR_LIVE + 12'h8, 32'h0);
    check(rd, 32'h0);
    upd(1'b1, 32'h0000_0099);
    wb(1'b0, ADR_LIVE + 12'h8, 32'h0);
    check(rd, 32'h0000_0099);
    cmd(OPC_MODE, 8'h00, 8'h02, ST_EINVAL);
    check({31'h0, rd[ST_STOP_BIT]}, 32'h1);
    cmd(OPC_REST, 8'h00, 8'h00, ST_OK);
    wb(1'b0, ADR_LIVE + 12'h4, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, ADR_REQBUF + 12'h8, 32'h0200_0001);
    wb(1'b1, ADR_REQBUF + 12'hc, 32'h0000_0077);
    cmd(OPC_REST, 8'h00, 8'h00, ST_EINVAL);
    wb(1'b1, ADR_REQBUF + 12'h8, 32'h0100_0000);
    cmd(OPC_REST, 8'h00, 8'h00, ST_EINVAL);
    cmd(OPC_MODE, 8'h00, 8'h00, ST_OK);
    check({30'h0, notifyEn, memAccessEn}, 32'h3);
    wb(1'b0, ADR_LIVE + 12'h4, 32'h0);
    check(rd, 32'h0000_0055);
  endtask : testRestore

  task automatic testCapture;
    wb(1'b1, ADR_RESCAP, 32'd32);
    wb(1'b1, ADR_PRESENT, 32'h3d);
    wb(1'b1, ADR_REQLEN, 32'd2);
    wb(1'b1, ADR_REQBUF, 32'h0100_0002);
    wb(1'b1, ADR_REQBUF + 12'h4, 32'h0100_0001);
    cmd(OPC_CAPT, CAPT_SELECTED, 8'h00, ST_OK);
    check({16'h0, rd[31:16]}, 32'd2);
    wb(1'b0, ADR_RESBUF, 32'h0);
    check({16'h0, rd[15:0]}, 32'h2);
    wb(1'b1, ADR_PRESENT, 32'h3f);
    wb(1'b1, ADR_REQLEN, 32'd0);
    cmd(OPC_CAPT, CAPT_ALL, 8'h00, ST_OK);
    check({16'h0, rd[31:16]}, 32'd12);
    wb(1'b0, ADR_RESBUF + 12'h8, 32'h0);
    check({16'h0, rd[15:0]}, 32'h1);
    wb(1'b0, ADR_RESBUF + 12'hc, 32'h0);
    check(rd, 32'h0000_0055);
    wb(1'b0, ADR_RESBUF + 12'h14, 32'h0);
    check(rd, 32'h0000_0099);
    wb(1'b1, ADR_RESCAP, 32'd3);
    cmd(OPC_CAPT, CAPT_ALL, 8'h00, ST_ENOMEM);
    cmd(8'h12, 8'h00, 8'h00, ST_EINVAL);
  endtask : testCapture

  task automatic conclude;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testMeta();
    testRestore();
    testCapture();
    conclude();
  end
endmodule : tb_top
